// [design/mwt_top.sv]
// Maintenance window translator: holds the outbound translation register and
// converts each in-range window access into one maintenance request with handshake.
// Assumes the local bus holds an access until accepted and the link side holds
// a response until taken; one access is outstanding at a time.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Maintenance offset is 24-bit, word aligned.
// - Config offset equals maintenance offset shifted three.
// - Word pointer picks lower or upper word.
// - 4M window: low 22 bits from access.
// - 4K window: low 12 bits from access.
// - Register holds target, hops, offset above twelve.
module mwt_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Setup
  input wire mwt_pkg::mwt_win_e win_size_i,
  input wire logic tar_we_i,
  input wire logic [mwt_pkg::MWT_TAR_W-1:0] tar_wdata_i,
  output logic [mwt_pkg::MWT_TAR_W-1:0] tar_rdata_o,
  // Local window access
  input wire logic acc_valid_i,
  input wire mwt_pkg::mwt_acc_s acc_i,
  output logic acc_ready_o,
  output logic acc_err_o,
  output logic rsp_valid_o,
  output logic [31:0] rsp_rdata_o,
  // Maintenance request toward the fabric
  output logic req_valid_o,
  output mwt_pkg::mwt_req_s req_o,
  input wire logic req_ready_i,
  // Maintenance response from the fabric
  input wire logic link_rsp_valid_i,
  input wire logic [31:0] link_rsp_data_i
);
  import mwt_pkg::*;

  typedef struct packed {
    mwt_state_e st;
    logic [MWT_TAR_W-1:0] tar;
    mwt_req_s req;
    logic err;
    logic rsp_v;
    logic [31:0] rdata;
  } mwt_state_s;

  mwt_state_s cur_ff;
  mwt_state_s nxt_cur;
  logic [MWT_MOFS_W-1:0] mofs;
  logic [MWT_CFG_W-1:0] cfg;
  logic wptr;
  logic in_range;
  logic [MWT_TAR_W-1:0] tar_eff;

  // A register write in the same cycle as an access is applied to that access,
  // so an update can never be overtaken by the access it was meant for.
  assign tar_eff = tar_we_i ? tar_wdata_i : cur_ff.tar;

  mwt_xlate u_xlate (
    .win_size_i(win_size_i),
    .tar_i(tar_eff),
    .ofs_i(acc_i.ofs),
    .mofs_o(mofs),
    .cfg_o(cfg),
    .wptr_o(wptr),
    .in_range_o(in_range)
  );

  assign acc_ready_o = (cur_ff.st == MWT_ST_IDLE);
  assign req_valid_o = (cur_ff.st == MWT_ST_SEND);
  assign req_o = cur_ff.req;
  assign tar_rdata_o = cur_ff.tar;
  assign acc_err_o = cur_ff.err;
  assign rsp_valid_o = cur_ff.rsp_v;
  assign rsp_rdata_o = cur_ff.rdata;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.err = 1'b0;
    nxt_cur.rsp_v = 1'b0;
    if (tar_we_i) begin
      nxt_cur.tar = tar_wdata_i;
    end
    case (cur_ff.st)
      MWT_ST_IDLE: begin
        if (acc_valid_i) begin
          if (!in_range) begin
            // An offset outside a 4 Kbyte window is refused, not wrapped.
            nxt_cur.err = 1'b1;
          end else begin
            nxt_cur.req.dest_id = tar_eff[MWT_TGT_POS +: MWT_DID_W];
            nxt_cur.req.hopcount = tar_eff[MWT_HOP_POS +: MWT_HOP_W];
            nxt_cur.req.cfg_offset = cfg;
            nxt_cur.req.wptr = wptr;
            nxt_cur.req.write = acc_i.write;
            nxt_cur.req.wdata = acc_i.wdata;
            nxt_cur.st = MWT_ST_SEND;
          end
        end
      end
      MWT_ST_SEND: begin
        if (req_ready_i) begin
          nxt_cur.st = MWT_ST_WAIT;
        end
      end
      MWT_ST_WAIT: begin
        if (link_rsp_valid_i) begin
          nxt_cur.rsp_v = 1'b1;
          nxt_cur.rdata = cur_ff.req.write ? 32'h00000000 : link_rsp_data_i;
          nxt_cur.st = MWT_ST_IDLE;
        end
      end
      default: begin
        nxt_cur.st = MWT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cur_ff <= '0;
      cur_ff.st <= MWT_ST_IDLE;
      cur_ff.tar <= MWT_TAR_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

endmodule : mwt_top
`default_nettype wire

// [design/mwt_pkg.sv]
// Package for the maintenance window translator: field widths, positions and the
// structs that carry a window access and the maintenance request built from it.
// Assumes a 32-bit local access whose offset is already relative to the window base.
package mwt_pkg;

  localparam int unsigned MWT_MOFS_W = 24;
  localparam int unsigned MWT_CFG_W = 21;
  localparam int unsigned MWT_DID_W = 8;
  localparam int unsigned MWT_HOP_W = 8;
  localparam int unsigned MWT_TOFS_W = 12;
  localparam int unsigned MWT_WIN_OFS_W = 22;
  localparam int unsigned MWT_WIN4M_LOW = 22;
  localparam int unsigned MWT_WIN4K_LOW = 12;
  localparam int unsigned MWT_DW_SHIFT = 3;
  localparam int unsigned MWT_TAR_SHIFT = 12;
  localparam int unsigned MWT_WPTR_BIT = 2;
  localparam logic [MWT_MOFS_W-1:0] MWT_MOFS_MAX = 24'h7ffffc;
  localparam logic [1:0] MWT_ALIGN_ZERO = 2'h0;

  // Translation register layout: target id, hop count, offset bits 23..12.
  localparam int unsigned MWT_TOFS_POS = 0;
  localparam int unsigned MWT_HOP_POS = 12;
  localparam int unsigned MWT_TGT_POS = 20;
  localparam int unsigned MWT_TAR_W = 28;
  localparam logic [MWT_TAR_W-1:0] MWT_TAR_RST = 28'h0000000;

  typedef enum logic [0:0] {
    MWT_WIN_4K = 1'b0,
    MWT_WIN_4M = 1'b1
  } mwt_win_e;

  typedef enum logic [1:0] {
    MWT_ST_IDLE = 2'b00,
    MWT_ST_SEND = 2'b01,
    MWT_ST_WAIT = 2'b10
  } mwt_state_e;

  typedef struct packed {
    logic [MWT_WIN_OFS_W-1:0] ofs;
    logic write;
    logic [31:0] wdata;
  } mwt_acc_s;

  typedef struct packed {
    logic [MWT_DID_W-1:0] dest_id;
    logic [MWT_HOP_W-1:0] hopcount;
    logic [MWT_CFG_W-1:0] cfg_offset;
    logic wptr;
    logic write;
    logic [31:0] wdata;
  } mwt_req_s;

endpackage : mwt_pkg

// [design/mwt_xlate.sv]
// Pure address former: turns the translation register and a window offset into
// the maintenance offset, the doubleword pointer and the word pointer.
// Assumes the caller registers its outputs; this module has no state.
`timescale 1ns/1ps
`default_nettype none
module mwt_xlate (
  // Setup
  input wire mwt_pkg::mwt_win_e win_size_i,
  input wire logic [mwt_pkg::MWT_TAR_W-1:0] tar_i,
  // Access
  input wire logic [mwt_pkg::MWT_WIN_OFS_W-1:0] ofs_i,
  // Result
  output logic [mwt_pkg::MWT_MOFS_W-1:0] mofs_o,
  output logic [mwt_pkg::MWT_CFG_W-1:0] cfg_o,
  output logic wptr_o,
  output logic in_range_o
);
  import mwt_pkg::*;

  logic [MWT_TOFS_W-1:0] tofs;
  logic [MWT_MOFS_W-1:0] upper;

  always_comb begin
    tofs = tar_i[MWT_TOFS_POS +: MWT_TOFS_W];
    upper = {tofs, 12'h000};
    if (win_size_i == MWT_WIN_4M) begin
      // Only register offset bits 11..10 reach the 4 Mbyte window.
      mofs_o = {upper[MWT_MOFS_W-1:MWT_WIN4M_LOW], ofs_i[MWT_WIN4M_LOW-1:0]};
      in_range_o = 1'b1;
    end else begin
      mofs_o = {tofs, ofs_i[MWT_WIN4K_LOW-1:0]};
      in_range_o = (ofs_i[MWT_WIN_OFS_W-1:MWT_WIN4K_LOW] == '0);
    end
    mofs_o[1:0] = MWT_ALIGN_ZERO;
    cfg_o = mofs_o[MWT_DW_SHIFT +: MWT_CFG_W];
    wptr_o = mofs_o[MWT_WPTR_BIT];
  end

endmodule : mwt_xlate
`default_nettype wire

// [dv/mwt_top_properties.sv]
// Checker on the translator top ports.
// Assumes a bind from the bench.
`timescale 1ns/1ps
`default_nettype none
module mwt_top_properties
  import mwt_pkg::*;
(
  // Watched ports
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire mwt_win_e win_size_i,
  input wire logic [27:0] tar_rdata_o,
  input wire logic acc_valid_i,
  input wire mwt_acc_s acc_i,
  input wire logic acc_ready_o,
  input wire logic acc_err_o,
  input wire logic req_valid_o,
  input wire mwt_req_s req_o,
  input wire logic req_ready_i
);
  wire logic tk = acc_valid_i && acc_ready_o;
  wire logic ok = win_size_i || acc_i.ofs[21:12] == 10'h000;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  property p_c4m; tk && win_size_i |=> req_o.cfg_offset ==
    {tar_rdata_o[11:10], $past(acc_i.ofs[21:3])}; endproperty
  a_c4m: assert property (p_c4m) else $error("bad cfg");
  property p_c4k; tk && ok && !win_size_i |=> req_o.cfg_offset ==
    {tar_rdata_o[11:0], $past(acc_i.ofs[11:3])}; endproperty
  a_c4k: assert property (p_c4k) else $error("bad cfg");
  property p_wp; tk && ok |=> req_o.wptr == $past(acc_i.ofs[2]); endproperty
  a_wp: assert property (p_wp) else $error("bad wptr");
  property p_id; tk && ok |=> {req_o.dest_id, req_o.hopcount} == tar_rdata_o[27:12];
  endproperty
  a_id: assert property (p_id) else $error("bad id");
  property p_err; tk && !ok |=> acc_err_o && !req_valid_o; endproperty
  a_err: assert property (p_err) else $error("no refusal");
  property p_hold; req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_o); endproperty
  a_hold: assert property (p_hold) else $error("req moved");
  property p_one; req_valid_o |-> !acc_ready_o; endproperty
  a_one: assert property (p_one) else $error("overlap");
endmodule : mwt_top_properties
`default_nettype wire

// [dv/mwt_fabric_model.sv]
// Behavioural fabric answering one maintenance request at a time.
// Assumes the bench sets slow_i to stall the ready line.
`timescale 1ns/1ps
`default_nettype none
module mwt_fabric_model
  import mwt_pkg::*;
(
  // Clock and pacing
  input wire logic clk_sys_i,
  input wire logic slow_i,
  // Request and response
  input wire logic req_valid_o,
  input wire mwt_req_s req_o,
  output var logic req_ready_i = 1'h0,
  output var logic link_rsp_valid_i = 1'h0,
  output var logic [31:0] link_rsp_data_i = 32'h0
);
  logic pend = 1'h0;
  logic [31:0] resp = 32'h0;
  always @(negedge clk_sys_i) begin
    req_ready_i = !slow_i || !req_ready_i;
    link_rsp_valid_i = pend;
    // Inverted idle data keeps a stale word from passing as a reply.
    link_rsp_data_i = pend ? resp : ~link_rsp_data_i;
    pend = req_valid_o && req_ready_i;
    resp = {req_o.dest_id, req_o.hopcount - 8'(req_o.hopcount != 8'h0),
      req_o.cfg_offset[15:0]};
  end
endmodule : mwt_fabric_model
`default_nettype wire

// [dv/tb_mwt_top.sv]
// Bench for the window translator against the fabric model.
// Assumes checker and model compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
  $display("wrong value at %0t ns: got %0h, expected %0h", $time, (a), (e)); end end
bind mwt_top mwt_top_properties u_props (.*);
module tb_mwt_top;
  import mwt_pkg::*;
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0, tar_we_i = 1'h0, acc_valid_i = 1'h0, slow_i = 1'h0;
  mwt_win_e win_size_i = MWT_WIN_4M;
  logic [27:0] tar_wdata_i = 28'h0, tar_rdata_o;
  mwt_acc_s acc_i = '0;
  mwt_req_s req_o;
  logic acc_ready_o, acc_err_o, rsp_valid_o, req_valid_o, req_ready_i, link_rsp_valid_i;
  logic [31:0] rsp_rdata_o, link_rsp_data_i;
  int err_count = 0, n_tests = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  mwt_top i_mwt_top (.*);
  mwt_fabric_model u_fabric (.*);
  task automatic end_of_test;
    $display("%0d checks, %0d wrong", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  task automatic maint(input logic [7:0] d, h, input logic [23:0] m, input logic w,
    input logic [21:0] o, input bit same = 1'b0);
    logic ok;
    ok = win_size_i == MWT_WIN_4M || o < 22'h001000;
    @(negedge clk_sys_i);
    tar_we_i = 1'h1;
    tar_wdata_i = {d, h, m[23:12]};
    // With same set, the register write and the access share one cycle.
    if (!same) begin
      @(negedge clk_sys_i);
      tar_we_i = 1'h0;
      `CHK({tar_rdata_o, acc_ready_o}, {tar_wdata_i, 1'h1})
    end
    acc_valid_i = 1'h1;
    acc_i = '{o, w, 32'hfff3210f};
    @(negedge clk_sys_i);
    tar_we_i = 1'h0;
    acc_valid_i = 1'h0;
    `CHK(tar_rdata_o, tar_wdata_i)
    `CHK({acc_err_o, req_valid_o}, {!ok, ok})
    if (ok) begin
      `CHK(req_o, {d, h, m[23:2], w, 32'hfff3210f})
      for (int i = 0; i < 9 && rsp_valid_o !== 1'h1; i++) @(negedge clk_sys_i);
      `CHK({rsp_valid_o, rsp_rdata_o}, {1'h1, w ? 32'h0 : {d, h - (h != 8'h0), m[18:3]}})
    end
  endtask : maint
  task automatic t_win(input mwt_win_e s, input logic [21:0] k);
    win_size_i = s;
    maint(8'h02, 8'hff, 24'h000068, 1'h0, 22'h000068 & k);
    slow_i = 1'h1;
    maint(8'hff, 8'h00, 24'h070a00, 1'h1, 22'h070a00 & k);
    maint(8'h04, 8'h02, 24'h7ffffc, 1'h0, 22'h3ffffc & k);
    slow_i = 1'h0;
    maint(8'h05, 8'h01, 24'h00a01c, 1'h0, 22'h00a01c & k, 1'h1);
    $display("window test done");
  endtask : t_win
  task automatic t_refuse;
    win_size_i = MWT_WIN_4K;
    maint(8'h03, 8'h01, 24'h001000, 1'h1, 22'h001000);
    $display("refusal test done");
  endtask : t_refuse
  initial begin
    repeat (5) @(negedge clk_sys_i);
    rst_b_i = 1'h1;
    `CHK({tar_rdata_o, req_valid_o}, 29'h0)
    t_win(MWT_WIN_4M, 22'h3fffff);
    t_win(MWT_WIN_4K, 22'h000fff);
    t_refuse;
    end_of_test;
  end
  // Nine accesses need about one microsecond; twenty times that is a hang.
  initial begin
    #20us;
    err_count++;
    end_of_test;
  end
endmodule : tb_mwt_top
`default_nettype wire
